// ---- design/ebt_pkg.sv ----
// Constants for the external bus timing block
package ebt_pkg;
  // Last phase of the three-period state time and the phase at which the state clock is high
  localparam logic [1:0] PH_LAST = 2'h2;
  localparam logic [1:0] PH_CLK_HIGH = 2'h2;
  // Idle waits for this phase so that cycle tick 0 lands on phase 0
  localparam logic [1:0] PH_PRE_START = 2'h2;
  // Cycle ticks, one oscillator period each, counted from the first address tick, one tick before the strobe falls
  localparam logic [3:0] T_ADDR_FIRST = 4'h0;
  localparam logic [3:0] T_LATCH = 4'h1;
  localparam logic [3:0] T_SAMPLE = 4'h2;
  localparam logic [3:0] T_WR_FALL = 4'h2;
  localparam logic [3:0] T_BYTE_WR = 4'h3;
  localparam logic [3:0] T_AFTER_SAMPLE = 4'h3;
  localparam logic [3:0] T_RD = 4'h4;
  localparam logic [3:0] T_WR_LOW_LAST = 4'h4;
  localparam logic [3:0] T_RD_LAST = 4'h5;
  localparam logic [3:0] T_DATA_HOLD = 4'h5;
  localparam logic [3:0] T_WR_STROBE_LAST = 4'h6;
  localparam logic [3:0] T_WR_LAST = 4'h8;
  // Wait state length in oscillator periods, minus one
  localparam logic [1:0] WAIT_LAST = 2'h2;
  // Package variants
  localparam logic WIDTH_PIN_PRESENT = 1'b1;
  localparam logic FETCH_PIN_PRESENT = 1'b1;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RST_PH = 2'h0;
  localparam logic [3:0] RST_TICK = 4'h0;
  localparam logic [1:0] RST_WAIT = 2'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} ebt_state_t;
endpackage

// ---- design/ebt_sync_if.sv ----
// Carrier between a raw input and its filtered copy
interface ebt_sync_if;
  logic raw;
  logic clean;
  modport syncer (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ---- design/ebt_sync3.sv ----
// Three-stage synchroniser that accepts a change once the last two stages agree
module ebt_sync3
  import ebt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ebt_sync_if.syncer port
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic clean_r;
  wire agree = s2_r == s3_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      clean_r <= 1'b0;
    end else begin
      s1_r <= port.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        clean_r <= s3_r;
      end
    end
  end

  assign port.clean = clean_r;
endmodule

// ---- design/ebt_bus.sv ----
// Multiplexed external bus controller with oscillator-domain pin sequencer
// Contract
// - State clock period is three oscillator periods
// - State clock high one oscillator period
// - Address valid one period around strobe fall
// - Byte write strobes two periods after fall
// - Read strobe low one oscillator period
// - Strobe rises one period after read ends
// - Fetch, upper enable held after; upper address too on eight-bit bus
// - Combined write strobe low three periods
// - Byte write strobes low two periods
// - Write data one period before byte strobes
// - Write data three before, one after rise
// - Strobe rises two periods after write ends
// - Fetch indicator high only on instruction fetches
// - Width sampled at first state clock rise
// - Config bit zero forces eight-bit bus
// - Without width pin, config bit decides
// - Ready low inserts three-period wait, resample
module ebt_bus
  import ebt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_input,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic req_fetch,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  input wire logic cfg_width_sel,
  input wire logic ready_in,
  input wire logic width_select_in,
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out,
  output logic ad_lo_oe_n,
  output logic ad_hi_oe_n,
  output logic addr_valid_strobe_n,
  output logic read_strobe_n,
  output logic write_n,
  output logic low_byte_write_n,
  output logic high_byte_write_n,
  output logic upper_byte_enable_n,
  output logic fetch_indicator,
  output logic state_clock_out
);
  function automatic logic in_win(input logic [3:0] t, input logic [3:0] lo, input logic [3:0] hi);
    in_win = (t >= lo) && (t <= hi);
  endfunction

  // User-side request holding and handshake
  logic busy_r;
  logic req_tog_r;
  logic ack_seen_r;
  logic resp_valid_r;
  logic [15:0] resp_rdata_r;
  logic [15:0] hold_addr_r;
  logic [15:0] hold_wdata_r;
  logic hold_write_r;
  logic hold_word_r;
  logic hold_fetch_r;

  // Oscillator-side sequencer
  ebt_state_t state_r;
  ebt_state_t state_nxt;
  logic [1:0] ph_r;
  logic [3:0] t_r;
  logic [3:0] t_nxt;
  logic [1:0] w_r;
  logic [1:0] w_nxt;
  logic second_r;
  logic second_nxt;
  logic wide_r;
  logic wide_nxt;
  logic req_seen_r;
  logic req_seen_nxt;
  logic ack_tog_r;
  logic ack_tog_nxt;
  logic [15:0] rdata_r;

  // Registered pins
  logic [15:0] ad_out_r;
  logic ad_lo_oe_n_r;
  logic ad_hi_oe_n_r;
  logic adv_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic wrl_n_r;
  logic wrh_n_r;
  logic bhe_n_r;
  logic fetch_r;
  logic state_clock_output_r;

  ebt_sync_if req_if ();
  ebt_sync_if ack_if ();
  ebt_sync_if rdy_if ();
  ebt_sync_if wid_if ();
  ebt_sync_if cfg_if ();

  // Word-wide handover is safe: holds stay put until the toggle round trip ends
  assign req_if.raw = req_tog_r;
  assign ack_if.raw = ack_tog_r;
  assign rdy_if.raw = ready_in;
  assign wid_if.raw = width_select_in;
  assign cfg_if.raw = cfg_width_sel;

  ebt_sync3 u_req_sync (.clk(osc_input), .rst(rst), .port(req_if.syncer));
  ebt_sync3 u_ack_sync (.clk(clk), .rst(rst), .port(ack_if.syncer));
  ebt_sync3 u_rdy_sync (.clk(osc_input), .rst(rst), .port(rdy_if.syncer));
  ebt_sync3 u_wid_sync (.clk(osc_input), .rst(rst), .port(wid_if.syncer));
  ebt_sync3 u_cfg_sync (.clk(osc_input), .rst(rst), .port(cfg_if.syncer));

  wire ack_evt = ack_if.clean ^ ack_seen_r;
  wire take_req = req_valid && !busy_r;

  assign req_ready = !busy_r;
  assign resp_valid = resp_valid_r;
  assign resp_rdata = resp_rdata_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      req_tog_r <= 1'b0;
      hold_addr_r <= RST_WORD;
      hold_wdata_r <= RST_WORD;
      hold_write_r <= 1'b0;
      hold_word_r <= 1'b0;
      hold_fetch_r <= 1'b0;
    end else if (take_req) begin
      busy_r <= 1'b1;
      req_tog_r <= ~req_tog_r;
      hold_addr_r <= req_addr;
      hold_wdata_r <= req_wdata;
      hold_write_r <= req_write;
      hold_word_r <= req_word;
      hold_fetch_r <= req_fetch;
    end else if (ack_evt) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_seen_r <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_rdata_r <= RST_WORD;
    end else begin
      ack_seen_r <= ack_if.clean;
      resp_valid_r <= ack_evt;
      if (ack_evt) begin
        resp_rdata_r <= rdata_r;
      end
    end
  end

  // Sequencer decode
  wire new_req = req_if.clean ^ req_seen_r;
  wire running = state_r == ST_RUN;
  wire active = state_r != ST_IDLE;
  wire is_wr = hold_write_r;
  wire [3:0] last_t = is_wr ? T_WR_LAST : T_RD_LAST;
  wire [3:0] adv_last = is_wr ? T_WR_STROBE_LAST : T_RD_LAST;
  wire width_decision = WIDTH_PIN_PRESENT ? (cfg_if.clean && wid_if.clean) : cfg_if.clean;
  wire at_sample = running && (t_r == T_SAMPLE);
  wire wide_now = at_sample ? width_decision : wide_r;
  wire need_second = !wide_r && hold_word_r && !second_r;
  wire [15:0] cycle_addr = second_r ? {hold_addr_r[15:1], 1'b1} : hold_addr_r;
  wire odd_byte = cycle_addr[0];

  always_comb begin
    state_nxt = state_r;
    t_nxt = t_r;
    w_nxt = w_r;
    second_nxt = second_r;
    wide_nxt = wide_r;
    req_seen_nxt = req_seen_r;
    ack_tog_nxt = ack_tog_r;
    unique case (state_r)
      ST_IDLE: begin
        if (new_req && ph_r == PH_PRE_START) begin
          state_nxt = ST_RUN;
          t_nxt = T_ADDR_FIRST;
          second_nxt = 1'b0;
          req_seen_nxt = req_if.clean;
        end
      end
      ST_RUN: begin
        if (t_r == T_SAMPLE) begin
          // Sampled at the first state clock rise after the strobe falls
          wide_nxt = width_decision;
          if (rdy_if.clean) begin
            t_nxt = t_r + 4'h1;
          end else begin
            state_nxt = ST_WAIT;
            w_nxt = RST_WAIT;
          end
        end else if (t_r == last_t) begin
          if (need_second) begin
            t_nxt = T_ADDR_FIRST;
            second_nxt = 1'b1;
          end else begin
            state_nxt = ST_IDLE;
            ack_tog_nxt = ~ack_tog_r;
          end
        end else begin
          t_nxt = t_r + 4'h1;
        end
      end
      ST_WAIT: begin
        // Three-period waits keep the cycle aligned to the state clock
        if (w_r == WAIT_LAST) begin
          w_nxt = RST_WAIT;
          if (rdy_if.clean) begin
            state_nxt = ST_RUN;
            t_nxt = T_AFTER_SAMPLE;
          end
        end else begin
          w_nxt = w_r + 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge osc_input or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      t_r <= RST_TICK;
      w_r <= RST_WAIT;
      second_r <= 1'b0;
      wide_r <= 1'b0;
      req_seen_r <= 1'b0;
      ack_tog_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      t_r <= t_nxt;
      w_r <= w_nxt;
      second_r <= second_nxt;
      wide_r <= wide_nxt;
      req_seen_r <= req_seen_nxt;
      ack_tog_r <= ack_tog_nxt;
    end
  end

  // Free-running state time; the bus cycle is locked to it
  always_ff @(posedge osc_input or posedge rst) begin
    if (rst) begin
      ph_r <= RST_PH;
    end else begin
      ph_r <= (ph_r == PH_LAST) ? RST_PH : ph_r + 2'h1;
    end
  end

  // Read capture at the end of the read strobe; memory must be valid by then
  // Pins lag the decode by one tick, so the strobe is still low at this edge
  wire capture = running && !is_wr && (t_r == T_RD_LAST);

  always_ff @(posedge osc_input or posedge rst) begin
    if (rst) begin
      rdata_r <= RST_WORD;
    end else if (capture) begin
      if (wide_r) begin
        rdata_r <= ad_in;
      end else if (second_r) begin
        rdata_r[15:8] <= ad_in[7:0];
      end else begin
        rdata_r <= {8'h00, ad_in[7:0]};
      end
    end
  end

  // Pin decode, every pin registered so all edges shift by the same period
  wire adv_act = active && in_win(t_r, T_LATCH, adv_last);
  wire rd_act = running && !is_wr && (t_r == T_RD);
  wire wr_act = active && is_wr && in_win(t_r, T_WR_FALL, T_WR_LOW_LAST);
  wire bw_act = running && is_wr && in_win(t_r, T_BYTE_WR, T_WR_LOW_LAST);
  wire lo_sel = !wide_now || hold_word_r || !odd_byte;
  wire hi_sel = wide_now && (hold_word_r || odd_byte);
  wire framed = active && (t_r <= T_RD_LAST);
  wire addr_phase = active && (t_r <= T_LATCH);
  wire data_phase = active && is_wr && in_win(t_r, T_WR_FALL, T_DATA_HOLD);
  wire hi_addr = addr_phase || (framed && (t_r >= T_SAMPLE) && !wide_now);
  wire hi_data = data_phase && wide_now;
  wire [7:0] lo_wdata = (!wide_now && second_r) ? hold_wdata_r[15:8] : hold_wdata_r[7:0];
  wire [7:0] hi_wdata = hold_word_r ? hold_wdata_r[15:8] : hold_wdata_r[7:0];
  wire [7:0] lo_lane = addr_phase ? cycle_addr[7:0] : lo_wdata;
  wire [7:0] hi_lane = hi_addr ? cycle_addr[15:8] : hi_wdata;
  wire fetch_act = FETCH_PIN_PRESENT && framed && hold_fetch_r;
  wire bhe_act = framed && (hold_word_r || odd_byte);

  always_ff @(posedge osc_input or posedge rst) begin
    if (rst) begin
      ad_out_r <= RST_WORD;
      ad_lo_oe_n_r <= 1'b1;
      ad_hi_oe_n_r <= 1'b1;
      adv_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      wrl_n_r <= 1'b1;
      wrh_n_r <= 1'b1;
      bhe_n_r <= 1'b1;
      fetch_r <= 1'b0;
      state_clock_output_r <= 1'b0;
    end else begin
      ad_out_r <= {hi_lane, lo_lane};
      ad_lo_oe_n_r <= !(addr_phase || data_phase);
      ad_hi_oe_n_r <= !(hi_addr || hi_data);
      adv_n_r <= !adv_act;
      rd_n_r <= !rd_act;
      wr_n_r <= !wr_act;
      wrl_n_r <= !(bw_act && lo_sel);
      wrh_n_r <= !(bw_act && hi_sel);
      bhe_n_r <= !bhe_act;
      fetch_r <= fetch_act;
      state_clock_output_r <= ph_r == PH_CLK_HIGH;
    end
  end

  assign ad_out = ad_out_r;
  assign ad_lo_oe_n = ad_lo_oe_n_r;
  assign ad_hi_oe_n = ad_hi_oe_n_r;
  assign addr_valid_strobe_n = adv_n_r;
  assign read_strobe_n = rd_n_r;
  assign write_n = wr_n_r;
  assign low_byte_write_n = wrl_n_r;
  assign high_byte_write_n = wrh_n_r;
  assign upper_byte_enable_n = bhe_n_r;
  assign fetch_indicator = fetch_r;
  assign state_clock_out = state_clock_output_r;
endmodule

// ---- bench/ebt_bus_monitor.sv ----
// Pin timing checker for the multiplexed bus controller
module ebt_bus_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_input,
  input wire logic [15:0] ad_out,
  input wire logic ad_lo_oe_n,
  input wire logic ad_hi_oe_n,
  input wire logic addr_valid_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic upper_byte_enable_n,
  input wire logic fetch_indicator,
  input wire logic state_clock_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge osc_input); endclocking
  default disable iff (rst);
  logic [9:0] lat_r;
  // Ticks since the strobe fell, so wait states show up as whole state times
  always_ff @(posedge osc_input or posedge rst) begin
    if (rst) lat_r <= 10'h000;
    else lat_r <= addr_valid_strobe_n ? 10'h000 : lat_r + 10'h001;
  end
  AST_STATE_CLOCK: assert property (
    $rose(state_clock_out) |=> !state_clock_out ##1 !state_clock_out ##1 state_clock_out) else $error("state clock");
  AST_ADDR_HOLD: assert property (
    $fell(addr_valid_strobe_n) |-> $stable(ad_out) && !ad_lo_oe_n && !$past(ad_lo_oe_n)) else $error("address");
  AST_ADDR_HI_HOLD: assert property (
    $fell(addr_valid_strobe_n) |-> !ad_hi_oe_n && !$past(ad_hi_oe_n)) else $error("upper address");
  AST_BYTE_DELAY: assert property (
    $fell(low_byte_write_n) |-> !addr_valid_strobe_n && !$past(addr_valid_strobe_n)
      && !$past(addr_valid_strobe_n, 2) && $past(addr_valid_strobe_n, 3)) else $error("byte strobe delay");
  AST_RD_WIDTH: assert property (
    $fell(read_strobe_n) |=> read_strobe_n) else $error("read width");
  AST_RD_GAP: assert property (
    $rose(read_strobe_n) |-> !addr_valid_strobe_n ##1 addr_valid_strobe_n) else $error("read gap");
  AST_QUAL_HOLD: assert property (
    $rose(read_strobe_n) || $rose(write_n) |-> $stable(fetch_indicator) && $stable(upper_byte_enable_n))
    else $error("qualifier hold");
  AST_WR_WIDTH: assert property (
    $fell(write_n) |=> !write_n ##1 !write_n ##1 write_n) else $error("write width");
  AST_BYTE_WIDTH: assert property (
    $fell(low_byte_write_n) |=> !low_byte_write_n ##1 low_byte_write_n) else $error("byte width");
  AST_DATA_SETUP: assert property (
    $fell(low_byte_write_n) |-> $stable(ad_out) && !$past(ad_lo_oe_n)) else $error("data setup");
  AST_DATA_HOLD: assert property (
    $fell(write_n) |-> !ad_lo_oe_n ##1 ($stable(ad_out) && !ad_lo_oe_n) [*3]) else $error("data hold");
  AST_WR_GAP: assert property (
    $rose(write_n) |-> !addr_valid_strobe_n ##1 !addr_valid_strobe_n ##1 addr_valid_strobe_n)
    else $error("write gap");
  AST_WAIT_STATES: assert property (
    $fell(read_strobe_n) |-> lat_r >= 10'h003 && lat_r % 10'h003 == 10'h000) else $error("wait length");
  cover property ($fell(read_strobe_n));
  cover property ($fell(write_n));
  cover property ($fell(high_byte_write_n));
  cover property ($fell(read_strobe_n) && lat_r > 10'h003);
endmodule
bind ebt_bus ebt_bus_monitor mon_u (.clk, .rst, .osc_input, .ad_out, .ad_lo_oe_n, .ad_hi_oe_n, .addr_valid_strobe_n,
  .read_strobe_n, .write_n, .low_byte_write_n, .high_byte_write_n, .upper_byte_enable_n,
  .fetch_indicator, .state_clock_out);

// ---- bench/ebt_mem_model.sv ----
// Behavioural byte memory on the far side of the multiplexed bus
module ebt_mem_model (
  input wire logic osc_input,
  input wire logic [15:0] ad_out,
  input wire logic addr_valid_strobe_n,
  input wire logic read_strobe_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic ready_lvl,
  input wire logic wide,
  output logic [15:0] ad_in,
  output logic ready_in,
  output logic width_select_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255];
  logic [7:0] a_r;
  logic adv_q;
  logic [15:0] word;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
  // Width changes only between cycles; ready may rise during wait states and is resampled after each wait
  assign ready_in = ready_lvl;
  assign width_select_in = wide;
  assign word = {mem[{a_r[7:1], 1'b1}], mem[a_r]};
  // Inverted outside the strobe so stale data can never pass for good data
  assign ad_in = read_strobe_n ? ~word : word;
  always @(posedge osc_input) begin
    adv_q <= addr_valid_strobe_n;
    if (!addr_valid_strobe_n && adv_q) a_r <= ad_out[7:0];
    if (!low_byte_write_n) mem[a_r] <= ad_out[7:0];
    if (!high_byte_write_n) mem[{a_r[7:1], 1'b1}] <= ad_out[15:8];
  end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the multiplexed bus controller
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, osc_input, req_valid, req_ready, req_write, req_word, req_fetch, resp_valid;
  logic cfg_width_sel, ready_in, width_select_in, ad_lo_oe_n, ad_hi_oe_n, addr_valid_strobe_n;
  logic read_strobe_n, write_n, low_byte_write_n, high_byte_write_n, upper_byte_enable_n;
  logic fetch_indicator, state_clock_out, ready_lvl, wide, fetch_seen;
  logic [15:0] req_addr, req_wdata, resp_rdata, ad_in, ad_out, q;
  int err_count, checks, falls, nf;
  time t0;
  ebt_bus dut_u (.clk, .rst, .osc_input, .req_valid, .req_ready, .req_addr, .req_wdata, .req_write,
    .req_word, .req_fetch, .resp_valid, .resp_rdata, .cfg_width_sel, .ready_in, .width_select_in,
    .ad_in, .ad_out, .ad_lo_oe_n, .ad_hi_oe_n, .addr_valid_strobe_n, .read_strobe_n, .write_n,
    .low_byte_write_n, .high_byte_write_n, .upper_byte_enable_n, .fetch_indicator, .state_clock_out);
  ebt_mem_model mem_u (.osc_input, .ad_out, .addr_valid_strobe_n, .read_strobe_n, .low_byte_write_n,
    .high_byte_write_n, .ready_lvl, .wide, .ad_in, .ready_in, .width_select_in);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Phase offset keeps the two clocks unrelated
  initial begin
    osc_input = 1'b0;
    #3.3;
    forever #7.5 osc_input = ~osc_input;
  end
  always @(negedge addr_valid_strobe_n) falls++;
  always @(negedge read_strobe_n) fetch_seen = fetch_indicator;
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task access(input logic wr, input logic wd, input logic fe, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    falls = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_word = wd;
    req_fetch = fe;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    cmp({15'h0000, req_ready}, 16'h0000);
    for (int i = 0; i < 500 && resp_valid !== 1'b1; i++) @(negedge clk);
    cmp({15'h0000, resp_valid}, 16'h0001);
    q = resp_rdata;
    nf = falls;
  endtask
  // Levels settle through the synchronisers before the next cycle
  task set_mode(input logic c, input logic w);
    cfg_width_sel = c;
    wide = w;
    repeat (10) @(negedge clk);
  endtask
  task t_wide;
    set_mode(1'b1, 1'b1);
    access(1'b1, 1'b1, 1'b0, 16'h0010, 16'hbeef);
    cmp(16'(nf), 16'h0001);
    access(1'b1, 1'b0, 1'b0, 16'h0013, 16'h7777);
    access(1'b0, 1'b1, 1'b0, 16'h0012, 16'h0000);
    cmp(q, {8'h77, 8'h12 ^ 8'h3c});
    access(1'b0, 1'b1, 1'b1, 16'h0010, 16'h0000);
    cmp(q, 16'hbeef);
    cmp({15'h0000, fetch_seen}, 16'h0001);
  endtask
  task t_narrow;
    set_mode(1'b1, 1'b0);
    access(1'b1, 1'b1, 1'b0, 16'h0020, 16'h1234);
    cmp(16'(nf), 16'h0002);
    access(1'b0, 1'b1, 1'b0, 16'h0020, 16'h0000);
    cmp(q, 16'h1234);
    cmp({15'h0000, fetch_seen}, 16'h0000);
  endtask
  task t_cfg_off;
    set_mode(1'b0, 1'b1);
    access(1'b0, 1'b1, 1'b0, 16'h0010, 16'h0000);
    cmp(q, 16'hbeef);
    cmp(16'(nf), 16'h0002);
  endtask
  task t_wait;
    set_mode(1'b1, 1'b1);
    ready_lvl = 1'b0;
    repeat (10) @(negedge clk);
    t0 = $time;
    fork
      access(1'b0, 1'b1, 1'b0, 16'h0020, 16'h0000);
      begin
        repeat (60) @(negedge clk);
        ready_lvl = 1'b1;
      end
    join
    cmp(q, 16'h1234);
    cmp({15'h0000, ($time - t0) > 480}, 16'h0001);
  endtask
  initial begin
    {rst, req_valid, req_write, req_word, req_fetch} = 5'h10;
    {req_addr, req_wdata} = 32'h0000_0000;
    {cfg_width_sel, ready_lvl, wide} = 3'h7;
    err_count = 0;
    checks = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_wide();
    t_narrow();
    t_cfg_off();
    t_wait();
    end_sim();
  end
  initial begin
    #40000;
    err_count++;
    end_sim();
  end
endmodule
